// ==== sicm_baud.sv ====
// half-bit tick generator: prescaler and divisor
`timescale 1ns/1ps
`default_nettype none
module sicm_baud
  import sicm_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // settings
  input wire logic run,
  input wire logic [1:0] cks,
  input wire logic [DIV_W-1:0] divisor,
  // tick
  output logic half_tick
);
  logic [5:0] pre_q;
  logic [DIV_W+3:0] cnt_q;
  logic [5:0] pre_top;
  logic [DIV_W+3:0] cnt_top;
  logic src_en;
  logic cnt_end;

  // source clock: peripheral clock / 1, 4, 16 or 64
  assign pre_top = 6'((7'h01 << {cks, 1'b0}) - 7'h01);
  assign src_en = (pre_q == pre_top);
  assign cnt_top = (DIV_W+4)'(HALF_BIT_SRC * (int'(divisor) + 1) - 1);
  assign cnt_end = src_en && (cnt_q == cnt_top);

  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      pre_q <= 6'h00;
      cnt_q <= '0;
      half_tick <= 1'b0;
    end
    else
    begin
      pre_q <= src_en ? 6'h00 : pre_q + 6'h01;
      if (src_en)
        cnt_q <= cnt_end ? '0 : cnt_q + 1'b1;
      half_tick <= cnt_end;
    end
  end
endmodule : sicm_baud
`default_nettype wire

// ==== sicm_line.sv ====
// open-drain driver for one line with its select field
`timescale 1ns/1ps
`default_nettype none
module sicm_line
  import sicm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level sources
  input wire sicm_lsel_t sel,
  input wire logic ser_lvl,
  input wire logic cond_lvl,
  // pin enable, high pulls the line low
  output logic oe
);
  logic lvl;

  assign lvl = (sel == LSEL_SERIAL) ? ser_lvl :
               (sel == LSEL_COND) ? cond_lvl :
               (sel == LSEL_LOW) ? 1'b0 : 1'b1;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      oe <= 1'b0;
    else
      oe <= ~lvl;
  end
endmodule : sicm_line
`default_nettype wire

// ==== sicm_master_rx.sv ====
// two-wire master receive unit with APB registers
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module sicm_master_rx
  import sicm_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // interrupt
  output logic IRQ,
  // clock line
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  // data line
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE
);
  // registers
  logic rie_q;
  logic ack_sel_q;
  logic [1:0] cks_q;
  sicm_cond_t cond_q;
  logic [DIV_W-1:0] brr_q;
  logic [7:0] tx_q;
  logic [7:0] rxd_q;
  logic [7:0] sh_q;
  logic [2:0] ist_q;
  logic [2:0] imsk_q;
  logic ovr_q;
  logic [31:0] rdata_q;
  // engine
  sicm_state_t st_q;
  logic [3:0] bit_q;
  logic hi_q;
  logic [1:0] ph_q;
  logic scl_ser_q;
  logic sda_ser_q;
  logic scl_cnd_q;
  logic sda_cnd_q;
  logic sda_hold_q;
  // bus decode
  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire setup_rd = PSEL && !PENABLE && !PWRITE;
  wire hit_ctrl = (PADDR == OFF_CTRL);
  wire hit_cond = (PADDR == OFF_COND);
  wire hit_brr = (PADDR == OFF_BRR);
  wire hit_txd = (PADDR == OFF_TXD);
  wire hit_rxd = (PADDR == OFF_RXD);
  wire hit_ist = (PADDR == OFF_IST);
  wire hit_imsk = (PADDR == OFF_IMSK);
  wire hit_err = (PADDR == OFF_ERR);
  wire mapped = hit_ctrl || hit_cond || hit_brr || hit_txd || hit_rxd ||
                hit_ist || hit_imsk || hit_err;
  assign PREADY = PENABLE;
  assign PSLVERR = acc && !mapped;
  assign PRDATA = rdata_q;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  // engine events
  wire tick;
  wire serial = (cond_q.scls == LSEL_SERIAL) && (cond_q.sdas == LSEL_SERIAL);
  wire gen_ok = (cond_q.scls == LSEL_COND) && (cond_q.sdas == LSEL_COND);
  wire idle = (st_q == ST_IDLE);
  wire go_byte = wr && hit_txd && idle && serial;
  wire go_sta = idle && gen_ok && cond_q.sta;
  wire go_stp = idle && gen_ok && cond_q.stp && !cond_q.sta;
  wire cond_end = tick && (ph_q == 2'h2) &&
                  ((st_q == ST_START) || (st_q == ST_STOP));
  wire fall = tick && (st_q == ST_BYTE) && hi_q;
  wire rx_done = fall && (bit_q == 4'h7);
  wire ack_done = fall && (bit_q == LAST_BIT);
  wire err_clr = wr && hit_err && PWDATA[ERR_OVR] && ovr_q;
  // flag set terms
  logic [2:0] ist_set;
  assign ist_set[IRQ_RX] = rx_done && rie_q;
  assign ist_set[IRQ_TX] = ack_done || err_clr;
  assign ist_set[IRQ_COND] = cond_end;
  wire [2:0] ist_clr = (wr && hit_ist) ? PWDATA[2:0] : 3'h0;
  wire done_wr0 = wr && hit_cond && !PWDATA[COND_DONE];
  assign IRQ = |(ist_q & imsk_q);
  sicm_baud #(.DIV_W(DIV_W)) u_baud
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .run(!idle),
    .cks(cks_q),
    .divisor(brr_q),
    .half_tick(tick)
  );
  sicm_line u_scl
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .sel(cond_q.scls),
    .ser_lvl(scl_ser_q),
    .cond_lvl(scl_cnd_q),
    .oe(SCL_OE)
  );
  sicm_line u_sda
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .sel(cond_q.sdas),
    .ser_lvl(sda_hold_q),
    .cond_lvl(sda_cnd_q),
    .oe(SDA_OE)
  );

  // read data mux, loaded in the setup cycle
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    if (hit_ctrl)
      rmux[CTRL_CKS+1:0] = {cks_q, ack_sel_q, rie_q};
    if (hit_cond)
      rmux[7:0] = {cond_q.sdas, cond_q.scls, 1'b0, cond_q.done,
                   cond_q.stp, cond_q.sta};
    if (hit_brr)
      rmux[DIV_W-1:0] = brr_q;
    if (hit_txd)
      rmux[7:0] = tx_q;
    if (hit_rxd)
      rmux[7:0] = rxd_q;
    if (hit_ist)
      rmux[2:0] = ist_q;
    if (hit_imsk)
      rmux[2:0] = imsk_q;
    if (hit_err)
      rmux[ERR_OVR] = ovr_q;
  end
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      rdata_q <= 32'h0000_0000;
    else if (setup_rd)
      rdata_q <= rmux;
  end

  // control and divisor registers
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      rie_q <= 1'b0;
      ack_sel_q <= 1'b0;
      cks_q <= CKS_RST;
      brr_q <= DIV_W'(BRR_RST);
      imsk_q <= IRQ_RST;
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        rie_q <= PWDATA[CTRL_RIE];
        ack_sel_q <= PWDATA[CTRL_ACK];
        cks_q <= PWDATA[CTRL_CKS+1:CTRL_CKS];
      end
      if (hit_brr && idle)
        brr_q <= PWDATA[DIV_W-1:0];
      if (hit_imsk)
        imsk_q <= PWDATA[2:0];
    end
  end

  // condition register: requests, done flag, line selects
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      cond_q <= COND_RST;
    else
    begin
      if (wr && hit_cond)
      begin
        cond_q.sta <= PWDATA[COND_STA];
        cond_q.stp <= PWDATA[COND_STP];
        cond_q.scls <= sicm_lsel_t'(PWDATA[COND_SCLS+1:COND_SCLS]);
        cond_q.sdas <= sicm_lsel_t'(PWDATA[COND_SDAS+1:COND_SDAS]);
        if (!PWDATA[COND_DONE])
          cond_q.done <= 1'b0;
      end
      if (cond_end && st_q == ST_START)
        cond_q.sta <= 1'b0;
      if (cond_end && st_q == ST_STOP)
        cond_q.stp <= 1'b0;
      if (cond_end)
        cond_q.done <= 1'b1;
    end
  end

  // sticky interrupt status, set wins over clear
  logic [2:0] ist_d;
  always_comb
  begin
    ist_d = ist_q & ~ist_clr;
    if (done_wr0)
      ist_d[IRQ_COND] = 1'b0;
    ist_d = ist_d | ist_set;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      ist_q <= IRQ_RST;
    else
      ist_q <= ist_d;
  end

  // overrun: byte done while receive flag still pending
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      ovr_q <= 1'b0;
    else if (rx_done && ist_q[IRQ_RX])
      ovr_q <= 1'b1;
    else if (err_clr)
      ovr_q <= 1'b0;
  end

  // received byte
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      rxd_q <= 8'h00;
    else if (rx_done)
      rxd_q <= {sh_q[6:0], SDA_IN};
  end

  // transfer engine
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      hi_q <= 1'b0;
      ph_q <= 2'h0;
      tx_q <= 8'h00;
      sh_q <= 8'h00;
      scl_ser_q <= 1'b0;
      sda_ser_q <= 1'b1;
      scl_cnd_q <= 1'b1;
      sda_cnd_q <= 1'b1;
      sda_hold_q <= 1'b1;
    end
    else
    begin
      // data moves a cycle after the clock falls: no false start
      sda_hold_q <= sda_ser_q;
      case (st_q)
        ST_IDLE:
        begin
          ph_q <= 2'h0;
          bit_q <= 4'h0;
          hi_q <= 1'b0;
          if (go_byte)
          begin
            // dummy byte written: drive first bit, clock in
            st_q <= ST_BYTE;
            tx_q <= PWDATA[7:0];
            sda_ser_q <= PWDATA[7];
            scl_ser_q <= 1'b0;
          end
          else if (go_sta)
            st_q <= ST_START;
          else if (go_stp)
            st_q <= ST_STOP;
        end
        ST_START:
        begin
          // both high, data falls, then clock falls
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            scl_cnd_q <= (ph_q != 2'h2);
            sda_cnd_q <= (ph_q == 2'h0);
            if (ph_q == 2'h2)
              st_q <= ST_IDLE;
          end
        end
        ST_STOP:
        begin
          // both low, clock rises, then data rises
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            scl_cnd_q <= (ph_q != 2'h0);
            sda_cnd_q <= (ph_q == 2'h2);
            if (ph_q == 2'h2)
              st_q <= ST_IDLE;
          end
        end
        ST_BYTE:
        begin
          if (tick && !hi_q)
          begin
            scl_ser_q <= 1'b1;
            hi_q <= 1'b1;
          end
          else if (fall)
          begin
            scl_ser_q <= 1'b0;
            hi_q <= 1'b0;
            bit_q <= bit_q + 4'h1;
            if (bit_q < LAST_BIT)
              sh_q <= {sh_q[6:0], SDA_IN};
            if (bit_q < 4'h7)
              sda_ser_q <= tx_q[3'(6 - int'(bit_q))];
            else if (bit_q == 4'h7)
              sda_ser_q <= ack_sel_q;
            else
            begin
              sda_ser_q <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule : sicm_master_rx
`default_nettype wire

// ==== sicm_master_rx_chk.sv ====
// port assertions for the master receive unit
`timescale 1ns/1ps
`default_nettype none
module sicm_master_rx_chk
  import sicm_pkg::*;
#(
  parameter int DIV_W = 8
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // register bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  // interrupt and lines
  input wire logic IRQ,
  input wire logic SCL_OE,
  input wire logic SDA_OE
);
  logic wr, sc_q, scl_up, scl_dn;
  logic [2:0] msk_q;
  logic [7:0] ctl_q;
  logic [DIV_W-1:0] brr_q;
  logic [3:0] nclk_q;
  logic [15:0] hi_q;
  logic [31:0] h;
  assign wr = PSEL && PENABLE && PWRITE;
  assign scl_up = sc_q && !SCL_OE;
  assign scl_dn = !sc_q && SCL_OE;
  // expected high half in clocks
  assign h = (32'd16 * (32'(brr_q) + 1)) << (2 * ctl_q[3:2]);
  always_ff @(posedge REF_CLK)
  begin
    sc_q <= SCL_OE;
    hi_q <= SCL_OE ? 16'h0 : hi_q + 16'h1;
    if (!RST_N)
    begin
      msk_q <= 3'h0;
      ctl_q <= 8'h00;
      brr_q <= '1;
      nclk_q <= 4'hF;
    end
    else
    begin
      if (wr && PADDR == OFF_IMSK) msk_q <= PWDATA[2:0];
      if (wr && PADDR == OFF_CTRL) ctl_q <= PWDATA[7:0];
      if (wr && PADDR == OFF_BRR) brr_q <= PWDATA[DIV_W-1:0];
      if (wr && PADDR == OFF_TXD) nclk_q <= 4'h0;
      else if (scl_up && nclk_q != 4'hF) nclk_q <= nclk_q + 4'h1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  property p_ready; PSEL |-> PREADY == PENABLE; endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_mask0; msk_q == 3'h0 |-> !IRQ; endproperty
  a_mask0: assert property (p_mask0) else $error("irq unmasked");
  property p_ack9;
    scl_up && nclk_q == 4'h8 |-> SDA_OE == !ctl_q[CTRL_ACK];
  endproperty
  a_ack9: assert property (p_ack9) else $error("ack level");
  property p_bit;
    scl_dn && nclk_q inside {[1:8]} |-> hi_q >= h - 1 && hi_q <= h + 4;
  endproperty
  a_bit: assert property (p_bit) else $error("bit time");
  property p_rx;
    scl_dn && nclk_q == 4'h8 && ctl_q[CTRL_RIE] && msk_q == 3'h1
      |-> ##[0:8] IRQ;
  endproperty
  a_rx: assert property (p_rx) else $error("no rx flag");
  property p_tx; scl_dn && nclk_q == 4'h9 && msk_q == 3'h2 |-> ##[0:8] IRQ;
  endproperty
  a_tx: assert property (p_tx) else $error("no tx flag");
  property p_done_clr;
    wr && PADDR == OFF_COND && !PWDATA[COND_DONE] && msk_q == 3'h4
      |=> !IRQ;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("irq kept");
  property p_release;
    wr && PADDR == OFF_COND && PWDATA[7:4] == 4'hF |-> ##3 !SCL_OE && !SDA_OE;
  endproperty
  a_release: assert property (p_release) else $error("not released");
endmodule : sicm_master_rx_chk
bind sicm_master_rx sicm_master_rx_chk #(.DIV_W(DIV_W)) u_chk
(
  .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .IRQ(IRQ), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE)
);
`default_nettype wire

// ==== sicm_master_rx_tb.sv ====
// bench for the master receive unit
`timescale 1ns/1ps
`default_nettype none
module sicm_master_rx_tb
  import sicm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd = 32'h0;
  logic rd_err = 1'b0;
  logic pready, pslverr, irq, scl_oe, sda_oe, slv_oe, ack_lvl, scl, sda;
  logic [7:0] tx_byte = 8'h3C;
  logic [7:0] dat [3] = '{8'h3C, 8'hA5, 8'h81};
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  assign scl = !scl_oe;
  assign sda = !sda_oe && !slv_oe;
  sicm_master_rx #(.DIV_W(8)) uut
  (
    .REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .SCL_IN(scl),
    .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe)
  );
  sicm_slave u_slv
  (
    .scl(scl), .sda(sda), .tx_byte(tx_byte), .sda_oe(slv_oe),
    .ack_lvl(ack_lvl)
  );
  initial
    forever #12.5 clk = ~clk;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, rd_err}, 32'h0);
  endtask : rdc
  task automatic wait_irq();
    @(posedge clk);
    for (int i = 0; i < 4000 && irq !== 1'b1; i++)
      @(posedge clk);
    chk({31'h0, irq}, 32'h1);
  endtask : wait_irq
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(OFF_CTRL, 32'h0);
    rdc(OFF_COND, 32'hF0);
    rdc(OFF_BRR, 32'hFF);
    // unmapped address: zero data and an error answer
    apb(1'b0, 5'h02, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    rdc(OFF_IST, 32'h0);
    apb(1'b1, OFF_BRR, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_IMSK, 32'h4);
    apb(1'b1, OFF_COND, 32'h51);
    wait_irq();
    rdc(OFF_COND, 32'h54);
    apb(1'b1, OFF_COND, 32'h00);
    rdc(OFF_IST, 32'h0);
    for (int n = 0; n < 3; n++)
    begin
      apb(1'b1, OFF_IMSK, n == 2 ? 32'h0 : 32'h1);
      if (n == 2)
        apb(1'b1, OFF_CTRL, 32'hB);
      apb(1'b1, OFF_TXD, 32'hFF);
      rd = 32'h0;
      if (n == 2)
        for (int k = 0; k < 4000 && rd[0] !== 1'b1; k++)
          apb(1'b0, OFF_ERR, 32'h0);
      else
        wait_irq();
      rdc(OFF_RXD, {24'h0, dat[n]});
      tx_byte <= dat[(n + 1) % 3];
      if (n != 1)
        apb(1'b1, OFF_IST, 32'h1);
      if (n == 2)
      begin
        apb(1'b1, OFF_ERR, 32'h1);
        rdc(OFF_IST, 32'h2);
        apb(1'b1, OFF_IST, 32'h2);
      end
      apb(1'b1, OFF_IMSK, 32'h2);
      wait_irq();
      apb(1'b1, OFF_IST, 32'h2);
      chk({31'h0, ack_lvl}, {31'h0, n == 2});
    end
    apb(1'b1, OFF_IMSK, 32'h4);
    apb(1'b1, OFF_COND, 32'h52);
    wait_irq();
    rdc(OFF_COND, 32'h54);
    apb(1'b1, OFF_CTRL, 32'h6);
    apb(1'b1, OFF_COND, 32'hF0);
    repeat (2) @(posedge clk);
    chk({29'h0, irq, scl_oe, sda_oe}, 32'h0);
    rdc(OFF_IST, 32'h0);
    chk({30'h0, scl, sda}, 32'h3);
    give_verdict();
  end
endmodule : sicm_master_rx_tb
`default_nettype wire

// ==== sicm_pkg.sv ====
// constants and types of the two-wire master receive unit
package sicm_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_COND = 5'h04;
  localparam logic [4:0] OFF_BRR = 5'h08;
  localparam logic [4:0] OFF_TXD = 5'h0C;
  localparam logic [4:0] OFF_RXD = 5'h10;
  localparam logic [4:0] OFF_IST = 5'h14;
  localparam logic [4:0] OFF_IMSK = 5'h18;
  localparam logic [4:0] OFF_ERR = 5'h1C;
  // control register fields
  localparam int CTRL_RIE = 0;
  localparam int CTRL_ACK = 1;
  localparam int CTRL_CKS = 2;
  // condition register fields
  localparam int COND_STA = 0;
  localparam int COND_STP = 1;
  localparam int COND_DONE = 2;
  localparam int COND_SCLS = 4;
  localparam int COND_SDAS = 6;
  // interrupt status and mask fields
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_COND = 2;
  localparam int ERR_OVR = 0;
  // reset values
  localparam logic [7:0] BRR_RST = 8'hFF;
  localparam logic [1:0] CKS_RST = 2'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // source clocks per half bit: 32 per bit
  localparam int HALF_BIT_SRC = 16;
  localparam logic [3:0] LAST_BIT = 4'h8;

  typedef enum logic [1:0]
  {
    LSEL_SERIAL = 2'b00,
    LSEL_COND = 2'b01,
    LSEL_LOW = 2'b10,
    LSEL_HIZ = 2'b11
  } sicm_lsel_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_STOP = 2'b10,
    ST_BYTE = 2'b11
  } sicm_state_t;

  typedef struct packed
  {
    sicm_lsel_t sdas;
    sicm_lsel_t scls;
    logic done;
    logic stp;
    logic sta;
  } sicm_cond_t;

  localparam sicm_cond_t COND_RST = '{LSEL_HIZ, LSEL_HIZ, 1'b0, 1'b0, 1'b0};
endpackage : sicm_pkg

// ==== sicm_slave.sv ====
// two-wire slave model sending bytes to the master
`timescale 1ns/1ps
`default_nettype none
module sicm_slave
(
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // byte to send
  input wire logic [7:0] tx_byte,
  // data pull and ack level seen
  output logic sda_oe,
  output logic ack_lvl
);
  int cnt = 9;
  logic quiet = 1'b1;
  initial sda_oe = 1'b0;
  initial ack_lvl = 1'b0;
  // start condition arms the model
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      cnt = 0;
      quiet = 1'b0;
    end
  // ninth clock: nack ends sending
  always @(posedge scl)
  begin
    if (cnt == 8)
    begin
      ack_lvl = sda;
      quiet = sda;
    end
    cnt = cnt == 8 ? 0 : cnt + 1;
  end
  always @(negedge scl)
    sda_oe = !quiet && cnt < 8 && !tx_byte[7 - cnt];
endmodule : sicm_slave
`default_nettype wire
